// [can_mode_pkg.sv]
// constants, mode encoding and timing for the transceiver mode control
// assumes a single 20 MHz clock and synchronous active-low reset
//
// Contract
// [RULE1] governing supply switch-off undervoltage forces Off from any mode
// [RULE2] Off is the state entered at power-up and reset
// [RULE3] in Off, bus outputs and receive output are undriven
// [RULE4] on supply recovery, wait startup time, then enter selected mode
// [RULE5] standby-select high selects Standby with the wake receiver watching
// [RULE6] Standby disables transmitter and Normal-mode receiver
// [RULE7] Standby biases bus outputs to ground, not mid-level
// [RULE8] after wake-up in Standby, receive output follows low-power receiver
// [RULE9] standby-select low gives Normal only with core and I/O supplies good
// [RULE10] core below standby threshold keeps Standby when select goes low
// [RULE11] held in Standby: clear pending wake, output low-power receiver data
// [RULE12] I/O variant: wake detection works while I/O supply is good
// [RULE13] Normal transmits from transmit input, receive output shows bus
// [RULE14] Normal transmits only after transmit input seen high once
// [RULE15] I/O variant: I/O undervoltage forces Off regardless of core supply
// [RULE16] Standby wakes on the standard dominant-recessive-dominant pattern
// [RULE17] pattern: dominant, recessive, dominant, each at least minimum time
// [RULE18] short intervals between qualifying phases are ignored
// [RULE19] Standby without wake-up keeps receive output high
// [RULE20] whole pattern must finish within timeout, else detector restarts
// [RULE21] no wake flagged if Normal is entered during pattern reception
// [RULE22] timings are cycle-count parameters; undervoltage flags synchronised
package can_mode_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ              = 20_000_000;
  localparam int STARTUP_US          = 50;
  localparam int WAKE_DOM_NS         = 500;
  localparam int WAKE_REC_NS         = 500;
  localparam int WAKE_TIMEOUT_US     = 1000;
  localparam int STARTUP_CYC         = STARTUP_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_DOM_CYC        =
    (WAKE_DOM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAKE_REC_CYC        =
    (WAKE_REC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAKE_TIMEOUT_CYC    = WAKE_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W               = 16;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_OFF     = 4'h1,
    MODE_BOOT    = 4'h2,
    MODE_STANDBY = 4'h4,
    MODE_NORMAL  = 4'h8
  } mode_t;

  // ****************************************
  // wake pattern detector states
  // ****************************************
  typedef enum logic [3:0] {
    WK_IDLE = 4'h1,
    WK_DOM1 = 4'h2,
    WK_REC  = 4'h4,
    WK_DOM2 = 4'h8
  } wake_t;

  localparam logic [1:0] BIAS_GROUND = 2'h0;
  localparam logic [1:0] BIAS_MID    = 2'h1;
  localparam logic [1:0] BIAS_FLOAT  = 2'h2;

endpackage : can_mode_pkg

// [can_wake_detect.sv]
// dominant-recessive-dominant wake pattern filter
// assumes bus_dom is already synchronised to clk
`timescale 1ns/100ps
`default_nettype none
module can_wake_detect #(
  parameter int DOM_CYC     = can_mode_pkg::WAKE_DOM_CYC,
  parameter int REC_CYC     = can_mode_pkg::WAKE_REC_CYC,
  parameter int TIMEOUT_CYC = can_mode_pkg::WAKE_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control
  input  wire logic enable,
  input  wire logic bus_dom,
  // result
  output logic      wake
);

  localparam int W = can_mode_pkg::CNT_W;

  can_mode_pkg::wake_t state;
  can_mode_pkg::wake_t next_state;
  logic [W-1:0]        phase_cnt;
  logic [W-1:0]        total_cnt;
  logic [W-1:0]        short_cnt;
  logic                next_wake;

  wire phase_dom = (state == can_mode_pkg::WK_DOM1) ||
                   (state == can_mode_pkg::WK_DOM2);
  // a level opposite to the wanted phase that is still short is a glitch
  wire opposite  = phase_dom ? !bus_dom : bus_dom;
  wire dom_done  = phase_cnt >= W'(DOM_CYC);
  wire rec_done  = phase_cnt >= W'(REC_CYC);
  wire short_max = phase_dom ? (short_cnt >= W'(REC_CYC))
                             : (short_cnt >= W'(DOM_CYC));
  wire timed_out = (state != can_mode_pkg::WK_IDLE) &&
                   (total_cnt >= W'(TIMEOUT_CYC));

  always_comb begin
    next_state = state;
    next_wake  = 1'b0;
    case (state)
      can_mode_pkg::WK_IDLE: begin
        if (bus_dom) next_state = can_mode_pkg::WK_DOM1;
      end
      can_mode_pkg::WK_DOM1: begin
        // [RULE17] first dominant phase
        if (dom_done && !bus_dom) next_state = can_mode_pkg::WK_REC;
        else if (!dom_done && opposite && short_max)
          next_state = can_mode_pkg::WK_IDLE;
      end
      can_mode_pkg::WK_REC: begin
        // [RULE17] recessive phase
        if (rec_done && bus_dom) next_state = can_mode_pkg::WK_DOM2;
      end
      can_mode_pkg::WK_DOM2: begin
        // [RULE16] pattern complete
        if (dom_done) begin
          next_wake  = 1'b1;
          next_state = can_mode_pkg::WK_IDLE;
        end
      end
      default: next_state = can_mode_pkg::WK_IDLE;
    endcase
    // [RULE20] restart on timeout
    if (timed_out) begin
      next_state = can_mode_pkg::WK_IDLE;
      next_wake  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      state     <= can_mode_pkg::WK_IDLE;
      phase_cnt <= '0;
      total_cnt <= '0;
      short_cnt <= '0;
      wake      <= 1'b0;
    end else begin
      state    <= next_state;
      wake     <= next_wake;
      if (state == can_mode_pkg::WK_IDLE) total_cnt <= '0;
      else if (!timed_out) total_cnt <= total_cnt + W'(1);
      if (next_state != state) begin
        phase_cnt <= '0;
        short_cnt <= '0;
      end else if (opposite) begin
        // [RULE18] short opposite intervals ignored
        short_cnt <= short_cnt + W'(1);
      end else begin
        short_cnt <= '0;
        if (!dom_done || !rec_done) phase_cnt <= phase_cnt + W'(1);
      end
    end
  end

endmodule : can_wake_detect
`default_nettype wire

// [can_mode_ctrl.sv]
// transceiver mode control: Off, startup, Standby and Normal
// assumes pins and undervoltage flags are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module can_mode_ctrl #(
  parameter bit          IO_VARIANT  = 1'b1,
  parameter int          STARTUP_CYC = can_mode_pkg::STARTUP_CYC,
  parameter int          DOM_CYC     = can_mode_pkg::WAKE_DOM_CYC,
  parameter int          REC_CYC     = can_mode_pkg::WAKE_REC_CYC,
  parameter int          TIMEOUT_CYC = can_mode_pkg::WAKE_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // controller side pins
  input  wire logic       tx_data,
  input  wire logic       standby_sel,
  output logic            rx_data,
  output logic            rx_data_oe,
  // supply monitors, high while under threshold
  input  wire logic       core_switchoff_uv_flag,
  input  wire logic       core_standby_uv_flag,
  input  wire logic       io_switchoff_uv_flag,
  // analog front end
  input  wire logic       bus_dom_normal,
  input  wire logic       bus_dom_lowpower,
  output logic            drive_dom,
  output logic [1:0]      bus_bias,
  output logic            normal_rx_en,
  output logic            lowpower_rx_en,
  // status
  output logic [3:0]      mode,
  output logic            wake_pending
);

  localparam int W = can_mode_pkg::CNT_W;

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NSYNC = 7;
  // syncs start on the safe side: supplies low, pins recessive, so the
  // first edges after reset cannot fake a supply recovery
  localparam logic [NSYNC-1:0] SYNC_SAFE = 7'h7c;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire  [NSYNC-1:0] raw_in = {tx_data, standby_sel, core_switchoff_uv_flag,
                              core_standby_uv_flag, io_switchoff_uv_flag,
                              bus_dom_normal, bus_dom_lowpower};

  // [RULE22] two-stage sync
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_a <= SYNC_SAFE;
      sync_b <= SYNC_SAFE;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire s_tx      = sync_b[6];
  wire s_stb     = sync_b[5];
  wire s_core_so = sync_b[4];
  wire s_core_sb = sync_b[3];
  wire s_io_so   = sync_b[2];
  wire s_dom_n   = sync_b[1];
  wire s_dom_lp  = sync_b[0];

  // ****************************************
  // supply decode
  // ****************************************
  // [RULE1] governing supply switch-off
  // [RULE15] I/O undervoltage alone decides Off on the I/O variant
  wire gov_off   = IO_VARIANT ? s_io_so : s_core_so;
  // [RULE9] Normal needs core above standby threshold
  wire normal_ok = !s_core_sb && !s_stb;
  // [RULE10] low select with weak core stays Standby
  wire held_stby = !s_stb && s_core_sb;

  // ****************************************
  // mode state machine
  // ****************************************
  can_mode_pkg::mode_t state;
  can_mode_pkg::mode_t next_state;
  logic [W-1:0]        boot_cnt;
  logic                tx_armed;
  logic                wake_seen;
  logic                held_last;
  wire                 wake_hit;
  wire boot_done = boot_cnt >= W'(STARTUP_CYC);

  always_comb begin
    next_state = state;
    case (state)
      can_mode_pkg::MODE_OFF: begin
        // [RULE4] begin initialisation on recovery
        if (!gov_off) next_state = can_mode_pkg::MODE_BOOT;
      end
      can_mode_pkg::MODE_BOOT: begin
        // [RULE4] selected mode after startup
        if (boot_done) next_state = normal_ok ? can_mode_pkg::MODE_NORMAL
                                              : can_mode_pkg::MODE_STANDBY;
      end
      can_mode_pkg::MODE_STANDBY: begin
        if (normal_ok) next_state = can_mode_pkg::MODE_NORMAL;
      end
      can_mode_pkg::MODE_NORMAL: begin
        // [RULE5] select high gives Standby
        if (!normal_ok) next_state = can_mode_pkg::MODE_STANDBY;
      end
      default: next_state = can_mode_pkg::MODE_OFF;
    endcase
    // [RULE1] Off from any mode
    if (gov_off) next_state = can_mode_pkg::MODE_OFF;
  end

  wire in_stby   = state == can_mode_pkg::MODE_STANDBY;
  wire in_normal = state == can_mode_pkg::MODE_NORMAL;
  // [RULE12] wake detection powered while governing supply is good
  // [RULE21] detector held in reset outside Standby
  wire det_en    = in_stby && !gov_off && !normal_ok;

  can_wake_detect #(
    .DOM_CYC     (DOM_CYC),
    .REC_CYC     (REC_CYC),
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_wake (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (det_en),
    .bus_dom (s_dom_lp),
    .wake    (wake_hit)
  );

  // [RULE2] Off after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= can_mode_pkg::MODE_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || state != can_mode_pkg::MODE_BOOT) begin
      boot_cnt <= '0;
    end else if (!boot_done) begin
      boot_cnt <= boot_cnt + W'(1);
    end
  end

  // [RULE14] arm transmitter after first high input
  always_ff @(posedge clk) begin
    if (!rst_b || !in_normal) begin
      tx_armed <= 1'b0;
    end else if (s_tx) begin
      tx_armed <= 1'b1;
    end
  end

  // [RULE11] clear pending wake when held in Standby
  always_ff @(posedge clk) begin
    if (!rst_b || !in_stby) begin
      wake_seen <= 1'b0;
      held_last <= 1'b0;
    end else begin
      held_last <= held_stby;
      if (wake_hit) wake_seen <= 1'b1;
      else if (held_stby && !held_last) wake_seen <= 1'b0;
    end
  end

  // ****************************************
  // output decode
  // ****************************************
  // [RULE8] follow low-power receiver after wake or when held
  wire lp_follow = wake_seen || held_stby;
  // [RULE19] otherwise high in Standby
  wire next_rx   = in_normal ? !s_dom_n :
                   lp_follow ? !s_dom_lp : 1'b1;
  // [RULE3] undriven in Off and during boot
  wire next_oe   = in_normal || in_stby;
  // [RULE13] drive from transmit input
  // [RULE6] no drive outside Normal
  wire next_drv  = in_normal && tx_armed && !s_tx;
  // [RULE7] ground bias in Standby
  wire [1:0] next_bias = in_normal ? can_mode_pkg::BIAS_MID :
                         in_stby   ? can_mode_pkg::BIAS_GROUND :
                                     can_mode_pkg::BIAS_FLOAT;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_data        <= 1'b1;
      rx_data_oe     <= 1'b0;
      drive_dom      <= 1'b0;
      bus_bias       <= can_mode_pkg::BIAS_FLOAT;
      normal_rx_en   <= 1'b0;
      lowpower_rx_en <= 1'b0;
      mode           <= can_mode_pkg::MODE_OFF;
      wake_pending   <= 1'b0;
    end else begin
      rx_data        <= next_rx;
      rx_data_oe     <= next_oe;
      drive_dom      <= next_drv;
      bus_bias       <= next_bias;
      normal_rx_en   <= in_normal;
      lowpower_rx_en <= in_stby;
      mode           <= state;
      wake_pending   <= wake_seen;
    end
  end

endmodule : can_mode_ctrl
`default_nettype wire

// [can_mode_chk.sv]
// assertions on the mode control ports
// assumes a bind from the testbench top
`timescale 1ns/100ps
`default_nettype none
module can_mode_chk (
  // clock and pins
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       tx_data,
  input  wire logic       core_standby_uv_flag,
  input  wire logic       io_switchoff_uv_flag,
  input  wire logic       bus_dom_normal,
  // outputs watched
  input  wire logic       rx_data,
  input  wire logic       rx_data_oe,
  input  wire logic       drive_dom,
  input  wire logic [1:0] bus_bias,
  input  wire logic       normal_rx_en,
  input  wire logic       lowpower_rx_en,
  input  wire logic [3:0] mode,
  input  wire logic       wake_pending
);
  // ****
  // transmit input seen high in Normal
  // ****
  logic seen;
  always_ff @(posedge clk) begin
    if (!rst_b || mode != 4'h8) seen <= 1'b0;
    else if (tx_data) seen <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  off_on_uv_a: assert property (
    io_switchoff_uv_flag [*5] |-> mode == 4'h1) else $error("no off");
  off_float_a: assert property (
    mode == 4'h1 && $past(mode) == 4'h1 |-> !rx_data_oe && !drive_dom
    && bus_bias == 2'h2) else $error("off drives");
  boot_time_a: assert property (
    $rose(mode == 4'h2) |-> (mode == 4'h2) [*8] ##[10:30] mode != 4'h2)
    else $error("startup time");
  stby_quiet_a: assert property (
    mode == 4'h4 && $past(mode) == 4'h4 |-> !drive_dom && !normal_rx_en
    && lowpower_rx_en && bus_bias == 2'h0) else $error("standby outputs");
  stby_rx_high_a: assert property (
    (mode == 4'h4 && !wake_pending && !core_standby_uv_flag) [*4]
    |-> rx_data) else $error("rx not high");
  norm_bias_a: assert property (
    mode == 4'h8 && $past(mode) == 4'h8 |-> bus_bias == 2'h1
    && normal_rx_en && rx_data_oe) else $error("normal outputs");
  norm_rx_a: assert property (
    (mode == 4'h8 && $stable(bus_dom_normal)) [*6]
    |-> rx_data == !bus_dom_normal) else $error("rx not bus");
  tx_first_a: assert property (
    drive_dom |-> seen) else $error("early transmit");
  wake_scope_a: assert property (
    wake_pending |-> mode == 4'h4 || $past(mode) == 4'h4)
    else $error("wake outside standby");
endmodule : can_mode_chk
`default_nettype wire

// [can_bus_model.sv]
// far side: bus wire with one outside node
// assumes clk is the design clock
`timescale 1ns/100ps
`default_nettype none
module can_bus_model (
  // clock
  input  wire logic clk,
  // wire parties
  input  wire logic drive_dom,
  input  wire logic lowpower_rx_en,
  input  wire logic ext_dom,
  // receivers
  output logic      bus_dom_normal,
  output logic      bus_dom_lowpower
);
  logic churn = 1'b0;
  // unpowered receiver is no stable level
  always @(posedge clk) churn <= !churn;
  assign bus_dom_normal = drive_dom | ext_dom;
  assign bus_dom_lowpower = lowpower_rx_en ? bus_dom_normal : churn;
endmodule : can_bus_model
`default_nettype wire

// [can_transceiver_mode_wakeup_control_tb_top.sv]
// self-checking bench for the mode control
// assumes the bus model and checker files compile first
`timescale 1ns/100ps
`default_nettype none
module can_transceiver_mode_wakeup_control_tb_top;
  logic       clk = 1'b0, rst_b = 1'b0, tx_data = 1'b1, standby_sel = 1'b1;
  logic       core_so = 1'b0, core_sb = 1'b0, io_so = 1'b1, ext_dom = 1'b0;
  logic       bus_n, bus_lp, rx_data, rx_oe, drive_dom, n_rx, lp_rx, wake;
  logic [1:0] bias;
  logic [3:0] mode;
  int         n_fail = 0, checked = 0;
  always #25 clk = !clk;
  can_mode_ctrl #(.STARTUP_CYC(20), .DOM_CYC(10), .REC_CYC(10),
    .TIMEOUT_CYC(200)) dut_u (.clk(clk), .rst_b(rst_b), .tx_data(tx_data),
    .standby_sel(standby_sel), .rx_data(rx_data), .rx_data_oe(rx_oe),
    .core_switchoff_uv_flag(core_so), .core_standby_uv_flag(core_sb),
    .io_switchoff_uv_flag(io_so), .bus_dom_normal(bus_n),
    .bus_dom_lowpower(bus_lp), .drive_dom(drive_dom), .bus_bias(bias),
    .normal_rx_en(n_rx), .lowpower_rx_en(lp_rx), .mode(mode),
    .wake_pending(wake));
  can_bus_model bus_u (.clk(clk), .drive_dom(drive_dom),
    .lowpower_rx_en(lp_rx), .ext_dom(ext_dom), .bus_dom_normal(bus_n),
    .bus_dom_lowpower(bus_lp));
  // ****
  // shared tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic phase(input logic dom, input int n);
    ext_dom = dom;
    cyc(n);
  endtask : phase
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic finish_test;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    #200_000;
    n_fail++;
    finish_test();
  end
  // ****
  // tests
  // ****
  initial begin
    cyc(2);
    rst_b = 1'b1;
    cyc(5);
    chk(mode, 4'h1);
    chk(rx_oe, 1'b0);
    chk(bias, 2'h2);
    done("off");
    io_so = 1'b0;
    tx_data = 1'b0;
    cyc(10);
    chk(mode, 4'h2);
    cyc(40);
    chk(mode, 4'h4);
    chk(bias, 2'h0);
    chk({n_rx, lp_rx}, 4'h1);
    chk(drive_dom, 1'b0);
    chk(rx_data, 1'b1);
    done("standby");
    phase(1'b1, 12);
    phase(1'b0, 250);
    phase(1'b1, 12);
    phase(1'b0, 6);
    chk(wake, 1'b0);
    chk(rx_data, 1'b1);
    // half pattern left over: let it time out before the next test
    phase(1'b0, 220);
    done("timeout");
    phase(1'b1, 12);
    phase(1'b0, 3);
    phase(1'b1, 3);
    phase(1'b0, 12);
    phase(1'b1, 4);
    phase(1'b0, 4);
    phase(1'b1, 12);
    phase(1'b0, 6);
    chk(wake, 1'b1);
    phase(1'b1, 6);
    chk(rx_data, 1'b0);
    phase(1'b0, 6);
    chk(rx_data, 1'b1);
    done("wake");
    // core lost while a wake is pending, then select low: held case
    core_so = 1'b1;
    core_sb = 1'b1;
    cyc(4);
    standby_sel = 1'b0;
    cyc(10);
    chk(mode, 4'h4);
    chk(wake, 1'b0);
    phase(1'b1, 6);
    chk(rx_data, 1'b0);
    phase(1'b0, 14);
    phase(1'b1, 13);
    phase(1'b0, 14);
    phase(1'b1, 13);
    phase(1'b0, 6);
    chk(wake, 1'b1);
    done("held");
    core_so = 1'b0;
    core_sb = 1'b0;
    cyc(10);
    chk(mode, 4'h8);
    chk(bias, 2'h1);
    chk(drive_dom, 1'b0);
    tx_data = 1'b1;
    cyc(6);
    tx_data = 1'b0;
    cyc(6);
    chk(drive_dom, 1'b1);
    chk(rx_data, 1'b0);
    tx_data = 1'b1;
    cyc(6);
    chk(rx_data, 1'b1);
    done("normal");
    // pattern cut by a visit to Normal must not complete afterwards
    standby_sel = 1'b1;
    cyc(10);
    chk(mode, 4'h4);
    chk(rx_data, 1'b1);
    phase(1'b1, 13);
    phase(1'b0, 14);
    standby_sel = 1'b0;
    phase(1'b1, 6);
    chk(mode, 4'h8);
    standby_sel = 1'b1;
    phase(1'b1, 8);
    phase(1'b0, 14);
    chk(mode, 4'h4);
    chk(wake, 1'b0);
    done("abort");
    io_so = 1'b1;
    cyc(8);
    chk(mode, 4'h1);
    chk(rx_oe, 1'b0);
    chk(bias, 2'h2);
    done("switch off");
    finish_test();
  end
endmodule : can_transceiver_mode_wakeup_control_tb_top
bind can_mode_ctrl can_mode_chk chk_u (.clk, .rst_b, .tx_data,
  .core_standby_uv_flag, .io_switchoff_uv_flag, .bus_dom_normal, .rx_data,
  .rx_data_oe, .drive_dom, .bus_bias, .normal_rx_en, .lowpower_rx_en,
  .mode, .wake_pending);
`default_nettype wire
